// ### include/pss_regs_map.vh
// Constants for the strap, skew, idle and checker register bank.
// Assumes inclusion by bare name from the design file.
`ifndef PSS_REGS_MAP_VH
`define PSS_REGS_MAP_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define PSS_IDX_W            7
`define PSS_IDX_MSB          8
`define PSS_IDX_LSB          2
`define PSS_IDX_CHK_MODE     7'h16
`define PSS_IDX_IDLE_CFG     7'h53
`define PSS_IDX_SKEW         7'h55
`define PSS_IDX_STRAP1       7'h6e
`define PSS_IDX_STRAP2       7'h6f
`define PSS_IDX_BYTE_TOTAL   7'h71
`define PSS_IDX_CHK_CTRL     7'h72

// ****************************************
// Field positions and reset values
// ****************************************
`define PSS_IDLE_THR_RST     4'h5
`define PSS_IDLE_CFG_UPPER   12'h205
`define PSS_CHK_LOCK_BIT     0
`define PSS_CHK_CLEAR_BIT    1
`define PSS_CHK_MODE_BIT     0
`define PSS_CHK_MODE_RST     1'h0
`define PSS_BYTE_TOTAL_RST   16'h0000
`define PSS_BYTE_TOTAL_MAX   16'hffff
`define PSS_RUN_MAX          4'hf
`define PSS_STRAP_W          21

// ****************************************
// Held strap word slots
// ****************************************
`define PSS_HS_RX_LSB        0
`define PSS_HS_RX_MSB        2
`define PSS_HS_TX_LSB        3
`define PSS_HS_TX_MSB        5
`define PSS_HS_QUICK_LOSS    6
`define PSS_HS_ADDR_LSB      7
`define PSS_HS_ADDR_MSB      10
`define PSS_HS_ANEG_SEL      11
`define PSS_HS_ANEG_OFF      12
`define PSS_HS_HALF_DUP      13
`define PSS_HS_FORCED_X      14
`define PSS_HS_AUTO_X_OFF    15
`define PSS_HS_SGMII_ON      16
`define PSS_HS_RGMII_OFF     17
`define PSS_HS_CLK_OFF       18
`define PSS_HS_DOWNSHIFT     19
`define PSS_HS_MIRROR        20

`endif

// ### hw/pss_regs.v
// Management register bank of the transceiver: idle detector threshold,
// receive lane skew status, strap mirrors and checker byte total.
// Assumes an Avalon-MM master on the same clock; strap pins are
// asynchronous, all other inputs come from logic on this clock.
// Strap pins must stand still for two clocks before reset is released;
// the captured straps then hold until the next reset.
// Writes take effect through byte lane 0 only.
//
// Operation
// - idle declared after threshold consecutive idle symbols; threshold bits 3:0, reset 0x5
// - lane A alignment cycles read-only in bits 3:0, zero after reset
// - lane B alignment cycles read-only in bits 7:4, zero after reset
// - strap bit 15 mirroring on, bit 14 downshift on, read-only
// - bit 13 clock output off, bit 12 RGMII off, bit 11 SGMII on
// - bit 10 auto crossover off, bit 9 forced MDIX 1 / MDI 0
// - bit 8 half duplex strap, bit 7 auto-negotiation off
// - bit 5 auto-negotiation select strap; bits 6 and 4 read zero
// - bits 3:0 show strapped management address
// - second strap register bit 10 shows fast link drop strap
// - second strap register bits 6:4 show transmit delay strap
// - bits 2:0 show receive delay strap; bit 3 reads zero
// - checker keeps 16-bit received byte total, reset 0x0000
// - readable total captured and held on write of control bit 0 or 1
// - with wrap mode zero the byte total saturates at 0xffff
// - control bit 0 locks counters; bit 1 locks and clears them
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "pss_regs_map.vh"

module pss_regs
#(
  parameter SKEW_W = 4,
  parameter THR_W  = 4,
  parameter CNT_W  = 16
)
(
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [8:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [3:0]  byteenable,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Idle detector symbol stream
  input  wire        symValid,
  input  wire        symIsIdle,
  output reg         idleMode,
  // Lane alignment from the receive path
  input  wire [3:0]  rxLaneAAlignCycles,
  input  wire [3:0]  rxLaneBAlignCycles,
  // Checker byte strobe
  input  wire        checkerByteValid,
  // Strap pins (asynchronous)
  input  wire        pinMirrorOn,
  input  wire        pinDownshiftOn,
  input  wire        pinClockOutputOff,
  input  wire        pinReducedGmiiOff,
  input  wire        pinSgmiiOn,
  input  wire        pinAutoCrossoverOff,
  input  wire        pinForcedCrossoverSel,
  input  wire        pinHalfDuplexOn,
  input  wire        pinAutonegOff,
  input  wire        pinAutonegSelect,
  input  wire [3:0]  pinMgmtAddress,
  input  wire        pinQuickLinkLossOn,
  input  wire [2:0]  pinTxDelayStrap,
  input  wire [2:0]  pinRxDelayStrap
);

  // ****************************************
  // Declarations
  // ****************************************
  reg                   ack_r;
  reg [THR_W-1:0]       idleRunThreshold_r;
  reg [THR_W-1:0]       runCnt_r;
  reg [THR_W-1:0]       runCnt_nxt;
  reg [SKEW_W-1:0]      laneASkew_r;
  reg [SKEW_W-1:0]      laneBSkew_r;
  reg [`PSS_STRAP_W-1:0] strapMeta_r;
  reg [`PSS_STRAP_W-1:0] strapSync_r;
  reg [`PSS_STRAP_W-1:0] strapHeld_r;
  reg                   strapCaught_r;
  reg                   checkerCountWrapMode_r;
  reg [CNT_W-1:0]       checkerByteTotal_r;
  reg [CNT_W-1:0]       checkerByteTotal_nxt;
  reg [CNT_W-1:0]       heldByteTotal_r;
  reg [15:0]            regRead;
  wire [`PSS_IDX_W-1:0] regIdx;
  wire                  wrFire;
  wire                  lowByteWr;
  wire                  lockReq;
  wire                  clearReq;
  wire [`PSS_STRAP_W-1:0] strapPins;
  wire [15:0]           strap1Val;
  wire [15:0]           strap2Val;
  wire                  idleCfgWr;
  wire                  chkModeWr;
  wire                  chkCtrlWr;

  // Held strap fields by name
  wire                  heldMirrorOn;
  wire                  heldDownshiftOn;
  wire                  heldClockOutputOff;
  wire                  heldReducedGmiiOff;
  wire                  heldSgmiiOn;
  wire                  heldAutoCrossoverOff;
  wire                  heldForcedCrossoverSel;
  wire                  heldHalfDuplexOn;
  wire                  heldAutonegOff;
  wire                  heldAutonegSelect;
  wire [3:0]            heldMgmtAddress;
  wire                  heldQuickLinkLossOn;
  wire [2:0]            heldTxDelay;
  wire [2:0]            heldRxDelay;

  // ****************************************
  // Bus handshake
  // ****************************************
  // Every access takes one wait cycle; write data lands on the edge at which
  // waitrequest is seen low; read data is registered one edge earlier
  assign regIdx      = address[`PSS_IDX_MSB:`PSS_IDX_LSB];
  assign waitrequest = (read | write) & ~ack_r;
  assign wrFire      = write & ack_r;
  assign lowByteWr   = wrFire & byteenable[0];

  // Register write strobes, taken from byte lane 0 only
  assign idleCfgWr   = lowByteWr && regIdx == `PSS_IDX_IDLE_CFG;
  assign chkModeWr   = lowByteWr && regIdx == `PSS_IDX_CHK_MODE;
  assign chkCtrlWr   = lowByteWr && regIdx == `PSS_IDX_CHK_CTRL;

  // Acknowledge toggles for one cycle per request
  always @(posedge clock)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= (read | write) & ~ack_r;
  end

  // ****************************************
  // Idle threshold and idle run detector
  // ****************************************
  // Writable threshold; upper bits are fixed and ignore writes
  always @(posedge clock)
  begin
    if (rst)
      idleRunThreshold_r <= `PSS_IDLE_THR_RST;
    else if (idleCfgWr)
      idleRunThreshold_r <= writedata[THR_W-1:0];
  end

  // Run length of consecutive idle symbols, saturating
  always @*
  begin
    runCnt_nxt = runCnt_r;
    if (symValid)
    begin
      if (!symIsIdle)
        runCnt_nxt = {THR_W{1'b0}};
      else if (runCnt_r != `PSS_RUN_MAX)
        runCnt_nxt = runCnt_r + 1'b1;
    end
  end

  // Idle mode is set while the run is at or above the threshold; a busy symbol clears it
  always @(posedge clock)
  begin
    if (rst)
    begin
      runCnt_r <= {THR_W{1'b0}};
      idleMode <= 1'b0;
    end
    else
    begin
      runCnt_r <= runCnt_nxt;
      if (symValid)
        idleMode <= symIsIdle && (runCnt_nxt >= idleRunThreshold_r);
    end
  end

  // ****************************************
  // Lane skew status
  // ****************************************
  // Snapshot of alignment cycles for readback
  always @(posedge clock)
  begin
    if (rst)
    begin
      laneASkew_r <= {SKEW_W{1'b0}};
      laneBSkew_r <= {SKEW_W{1'b0}};
    end
    else
    begin
      laneASkew_r <= rxLaneAAlignCycles;
      laneBSkew_r <= rxLaneBAlignCycles;
    end
  end

  // ****************************************
  // Strap capture
  // ****************************************
  // Pin word, one slot per strap field
  assign strapPins = {pinMirrorOn, pinDownshiftOn, pinClockOutputOff,
                      pinReducedGmiiOff, pinSgmiiOn, pinAutoCrossoverOff,
                      pinForcedCrossoverSel, pinHalfDuplexOn, pinAutonegOff,
                      pinAutonegSelect, pinMgmtAddress, pinQuickLinkLossOn,
                      pinTxDelayStrap, pinRxDelayStrap};

  // Two-stage synchroniser for the asynchronous strap pins
  always @(posedge clock)
  begin
    strapMeta_r <= strapPins;
    strapSync_r <= strapMeta_r;
  end

  // Latch the straps once, on the first edge after reset release
  always @(posedge clock)
  begin
    if (rst)
    begin
      strapCaught_r <= 1'b0;
      strapHeld_r   <= {`PSS_STRAP_W{1'b0}};
    end
    else if (!strapCaught_r)
    begin
      strapCaught_r <= 1'b1;
      strapHeld_r   <= strapSync_r;
    end
  end

  // ****************************************
  // Held strap fields
  // ****************************************
  // Named slices of the held strap word
  assign heldMirrorOn           = strapHeld_r[`PSS_HS_MIRROR];
  assign heldDownshiftOn        = strapHeld_r[`PSS_HS_DOWNSHIFT];
  assign heldClockOutputOff     = strapHeld_r[`PSS_HS_CLK_OFF];
  assign heldReducedGmiiOff     = strapHeld_r[`PSS_HS_RGMII_OFF];
  assign heldSgmiiOn            = strapHeld_r[`PSS_HS_SGMII_ON];
  assign heldAutoCrossoverOff   = strapHeld_r[`PSS_HS_AUTO_X_OFF];
  assign heldForcedCrossoverSel = strapHeld_r[`PSS_HS_FORCED_X];
  assign heldHalfDuplexOn       = strapHeld_r[`PSS_HS_HALF_DUP];
  assign heldAutonegOff         = strapHeld_r[`PSS_HS_ANEG_OFF];
  assign heldAutonegSelect      = strapHeld_r[`PSS_HS_ANEG_SEL];
  assign heldMgmtAddress        = strapHeld_r[`PSS_HS_ADDR_MSB:`PSS_HS_ADDR_LSB];
  assign heldQuickLinkLossOn    = strapHeld_r[`PSS_HS_QUICK_LOSS];
  assign heldTxDelay            = strapHeld_r[`PSS_HS_TX_MSB:`PSS_HS_TX_LSB];
  assign heldRxDelay            = strapHeld_r[`PSS_HS_RX_MSB:`PSS_HS_RX_LSB];

  // Primary strap layout with reserved bits 6 and 4 at zero
  assign strap1Val = {heldMirrorOn, heldDownshiftOn, heldClockOutputOff, heldReducedGmiiOff,
                      heldSgmiiOn, heldAutoCrossoverOff, heldForcedCrossoverSel, heldHalfDuplexOn,
                      heldAutonegOff,
                      1'b0,
                      heldAutonegSelect,
                      1'b0,
                      heldMgmtAddress};

  // Secondary strap layout; all reserved bits read zero
  assign strap2Val = {5'h00,
                      heldQuickLinkLossOn,
                      3'h0,
                      heldTxDelay,
                      1'b0,
                      heldRxDelay};

  // ****************************************
  // Checker byte total
  // ****************************************
  assign lockReq  = chkCtrlWr &&
                    (writedata[`PSS_CHK_LOCK_BIT] | writedata[`PSS_CHK_CLEAR_BIT]);
  assign clearReq = chkCtrlWr && writedata[`PSS_CHK_CLEAR_BIT];

  // Count mode selects saturate (0) or wrap (1)
  always @(posedge clock)
  begin
    if (rst)
      checkerCountWrapMode_r <= `PSS_CHK_MODE_RST;
    else if (chkModeWr)
      checkerCountWrapMode_r <= writedata[`PSS_CHK_MODE_BIT];
  end

  // Live total; a byte arriving with a clear is counted after the clear
  always @*
  begin
    checkerByteTotal_nxt = checkerByteTotal_r;
    if (clearReq)
      checkerByteTotal_nxt = {CNT_W{1'b0}};
    if (checkerByteValid)
    begin
      if (checkerCountWrapMode_r || checkerByteTotal_nxt != `PSS_BYTE_TOTAL_MAX)
        checkerByteTotal_nxt = checkerByteTotal_nxt + 1'b1;
    end
  end

  // Readable copy only changes on lock
  always @(posedge clock)
  begin
    if (rst)
    begin
      checkerByteTotal_r <= `PSS_BYTE_TOTAL_RST;
      heldByteTotal_r    <= `PSS_BYTE_TOTAL_RST;
    end
    else
    begin
      checkerByteTotal_r <= checkerByteTotal_nxt;
      if (lockReq)
        heldByteTotal_r <= checkerByteTotal_r;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Register select; unmapped addresses read zero
  always @*
  begin
    regRead = 16'h0000;
    case (regIdx)
      `PSS_IDX_IDLE_CFG:   regRead = {`PSS_IDLE_CFG_UPPER, idleRunThreshold_r};
      `PSS_IDX_SKEW:       regRead = {8'h00, laneBSkew_r, laneASkew_r};
      `PSS_IDX_STRAP1:     regRead = strap1Val;
      `PSS_IDX_STRAP2:     regRead = strap2Val;
      `PSS_IDX_BYTE_TOTAL: regRead = heldByteTotal_r;
      `PSS_IDX_CHK_MODE:   regRead = {15'h0000, checkerCountWrapMode_r};
      default:             regRead = 16'h0000;
    endcase
  end

  // Read data registered on the wait cycle, stands on the answer edge
  always @(posedge clock)
  begin
    if (rst)
      readdata <= 32'h00000000;
    else if (read && !ack_r)
      readdata <= {16'h0000, regRead};
  end

endmodule

// ### tb/pss_regs_props.sv
// Port checker for the strap, skew, idle and checker register bank.
// Assumes it is bound onto pss_regs; one clock, synchronous active-high reset.
`timescale 1ns/1ps
`include "pss_regs_map.vh"
module pss_regs_props
(
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // Avalon-MM slave
  input wire [8:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Idle detector
  input wire        symValid,
  input wire        symIsIdle,
  input wire        idleMode
);
  // ****************************************
  // Bus and idle detector properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // Read completion qualifiers for one index
  wire       req = read | write;
  wire       rdDone = read & ~waitrequest;
  wire [6:0] idx = address[8:2];
  a_wait_first: assert property (req && !$past(req) |-> waitrequest) else $error("no wait on first cycle");
  a_wait_once: assert property (req && waitrequest |=> !waitrequest) else $error("wait longer than one cycle");
  a_no_wait_idle: assert property (!req |-> !waitrequest) else $error("wait without request");
  a_upper_zero: assert property (rdDone |-> readdata[31:16] == 16'h0000) else $error("upper half not zero");
  a_idle_rise_cause: assert property ($rose(idleMode) |-> $past(symValid && symIsIdle)) else $error("idle rose");
  a_idle_busy_drop: assert property (symValid && !symIsIdle |=> !idleMode) else $error("idle after busy");
  a_idle_hold: assert property (!symValid |=> $stable(idleMode)) else $error("idle moved with no symbol");
  a_reset_clear: assert property (disable iff (1'b0) rst |=> !idleMode && readdata == 32'h0) else $error("reset");
  a_skew_upper: assert property (rdDone && idx == `PSS_IDX_SKEW |-> readdata[15:8] == 8'h00) else $error("skew hi");
  a_strap1_resv: assert property (rdDone && idx == `PSS_IDX_STRAP1 |-> !readdata[6] && !readdata[4])
    else $error("strap1 reserved");
  a_strap2_resv: assert property (rdDone && idx == `PSS_IDX_STRAP2
    |-> readdata[15:11] == 5'h00 && readdata[9:7] == 3'h0 && !readdata[3]) else $error("strap2 reserved");
  c_read: cover property (rdDone);
  c_write: cover property (write && !waitrequest);
  c_idle: cover property ($rose(idleMode));
endmodule
bind pss_regs pss_regs_props u_props (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .symValid(symValid), .symIsIdle(symIsIdle), .idleMode(idleMode));

// ### tb/pss_tb_top.sv
// Self-checking bench for the register bank over Avalon-MM.
// Assumes pss_regs and its map header; straps are set before reset release.
`timescale 1ns/1ps
`include "pss_regs_map.vh"
module tb_top;
  // ****************************************
  // Stimulus and observation signals
  // ****************************************
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         read = 1'b0;
  reg         write = 1'b0;
  reg         symValid = 1'b0;
  reg         symIsIdle = 1'b0;
  reg         checkerByteValid = 1'b0;
  reg         ql = 1'b1;
  reg [8:0]   address = 9'h000;
  reg [3:0]   byteenable = 4'hf;
  reg [3:0]   laneA = 4'h0;
  reg [3:0]   laneB = 4'h0;
  reg [3:0]   addr = 4'ha;
  reg [9:0]   s = 10'h2ab;
  reg [2:0]   tx = 3'h5;
  reg [2:0]   rx = 3'h3;
  reg [31:0]  writedata = 32'h0;
  reg [31:0]  q;
  wire [31:0] readdata;
  wire        waitrequest;
  wire        idleMode;
  integer     n_fail = 0;
  integer     num_checks = 0;
  integer     cyc = 0;
  // Free-running clock, 40 ns period
  always #20 clock = ~clock;
  pss_regs dut (.clock, .rst, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
    .symValid, .symIsIdle, .idleMode, .rxLaneAAlignCycles(laneA), .rxLaneBAlignCycles(laneB), .checkerByteValid,
    .pinMirrorOn(s[9]), .pinDownshiftOn(s[8]), .pinClockOutputOff(s[7]), .pinReducedGmiiOff(s[6]),
    .pinSgmiiOn(s[5]), .pinAutoCrossoverOff(s[4]), .pinForcedCrossoverSel(s[3]), .pinHalfDuplexOn(s[2]),
    .pinAutonegOff(s[1]), .pinAutonegSelect(s[0]), .pinMgmtAddress(addr), .pinQuickLinkLossOn(ql),
    .pinTxDelayStrap(tx), .pinRxDelayStrap(rx));
  // ****************************************
  // Shared tasks
  // ****************************************
  task test_done;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One bus cycle held until waitrequest is sampled low
  task bus(input [6:0] idx, input w, input [31:0] d);
    begin
      @(posedge clock);
      address <= {idx, 2'b00};
      read <= ~w;
      write <= w;
      writedata <= d;
      @(posedge clock);
      while (waitrequest !== 1'b0)
        @(posedge clock);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
    end
  endtask
  task rd(input [6:0] idx, input [31:0] exp);
    begin
      bus(idx, 1'b0, 32'h0);
      chk(q, exp);
    end
  endtask
  // One valid symbol, then a gap cycle
  task sym(input idle, input exp);
    begin
      @(posedge clock);
      symValid <= 1'b1;
      symIsIdle <= idle;
      @(posedge clock);
      symValid <= 1'b0;
      #1 chk({31'h0, idleMode}, {31'h0, exp});
    end
  endtask
  task pulse(input integer n);
    begin
      @(posedge clock);
      checkerByteValid <= 1'b1;
      repeat (n) @(posedge clock);
      checkerByteValid <= 1'b0;
    end
  endtask
  // Hang guard
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 90000)
    begin
      n_fail = n_fail + 1;
      test_done;
    end
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd(`PSS_IDX_IDLE_CFG, 32'h2055);
    rd(`PSS_IDX_SKEW, 32'h0);
    rd(`PSS_IDX_BYTE_TOTAL, 32'h0);
    rd(`PSS_IDX_CHK_MODE, 32'h0);
    rd(7'h7f, 32'h0);
    $display("test reset values done");
    rd(`PSS_IDX_STRAP1, 32'haaaa);
    rd(`PSS_IDX_STRAP2, 32'h0453);
    s <= 10'h154;
    addr <= 4'h5;
    ql <= 1'b0;
    tx <= 3'h2;
    rx <= 3'h4;
    bus(`PSS_IDX_STRAP1, 1'b1, 32'hffff);
    bus(`PSS_IDX_STRAP2, 1'b1, 32'hffff);
    rd(`PSS_IDX_STRAP1, 32'haaaa);
    rd(`PSS_IDX_STRAP2, 32'h0453);
    laneA <= 4'h3;
    laneB <= 4'hc;
    bus(`PSS_IDX_SKEW, 1'b1, 32'hffff);
    rd(`PSS_IDX_SKEW, 32'h00c3);
    $display("test straps and skew done");
    bus(`PSS_IDX_IDLE_CFG, 1'b1, 32'hfff4);
    rd(`PSS_IDX_IDLE_CFG, 32'h2054);
    byteenable <= 4'he;
    bus(`PSS_IDX_IDLE_CFG, 1'b1, 32'h3);
    byteenable <= 4'hf;
    rd(`PSS_IDX_IDLE_CFG, 32'h2054);
    sym(1'b1, 1'b0);
    sym(1'b1, 1'b0);
    sym(1'b1, 1'b0);
    sym(1'b1, 1'b1);
    sym(1'b1, 1'b1);
    sym(1'b0, 1'b0);
    sym(1'b1, 1'b0);
    $display("test idle threshold done");
    pulse(3);
    bus(`PSS_IDX_CHK_CTRL, 1'b1, 32'h1);
    rd(`PSS_IDX_BYTE_TOTAL, 32'h3);
    pulse(2);
    rd(`PSS_IDX_BYTE_TOTAL, 32'h3);
    bus(`PSS_IDX_CHK_CTRL, 1'b1, 32'h2);
    rd(`PSS_IDX_BYTE_TOTAL, 32'h5);
    bus(`PSS_IDX_CHK_CTRL, 1'b1, 32'h1);
    rd(`PSS_IDX_BYTE_TOTAL, 32'h0);
    pulse(65540);
    bus(`PSS_IDX_CHK_CTRL, 1'b1, 32'h1);
    bus(`PSS_IDX_BYTE_TOTAL, 1'b1, 32'h1234);
    rd(`PSS_IDX_BYTE_TOTAL, 32'hffff);
    bus(`PSS_IDX_CHK_MODE, 1'b1, 32'h1);
    rd(`PSS_IDX_CHK_MODE, 32'h1);
    pulse(1);
    bus(`PSS_IDX_CHK_CTRL, 1'b1, 32'h1);
    rd(`PSS_IDX_BYTE_TOTAL, 32'h0);
    $display("test checker total done");
    test_done;
  end
endmodule
